// ==== core/pmr_pkg.sv ====
// constants and types for the setpoint and alert mask command registers
package pmr_pkg;

  // command codes
  localparam logic [7:0] PMR_CMD_FEATURE  = 8'h19;
  localparam logic [7:0] PMR_CMD_MASK     = 8'h1b;
  localparam logic [7:0] PMR_CMD_VFORMAT  = 8'h20;
  localparam logic [7:0] PMR_CMD_SETPOINT = 8'h21;

  // fixed read-only contents and the setpoint reset value
  localparam logic [7:0]  PMR_FEATURE_VAL = 8'hb0;
  localparam logic [2:0]  PMR_VMODE_LIN   = 3'h0;
  localparam logic [4:0]  PMR_VEXP_M9     = 5'h17;
  localparam logic [11:0] PMR_SP_RST      = 12'h1e6;
  localparam logic [7:0]  PMR_MASK_CNT    = 8'h01;

  // accepted mask targets, index order 0..6
  localparam logic [7:0] PMR_TGT_WORD  = 8'h79;
  localparam logic [7:0] PMR_TGT_VOUT  = 8'h7a;
  localparam logic [7:0] PMR_TGT_IOUT  = 8'h7b;
  localparam logic [7:0] PMR_TGT_INPUT = 8'h7c;
  localparam logic [7:0] PMR_TGT_TEMP  = 8'h7d;
  localparam logic [7:0] PMR_TGT_CML   = 8'h7e;
  localparam logic [7:0] PMR_TGT_MFR   = 8'h80;
  localparam logic [2:0] PMR_TGT_NONE  = 3'h7;
  localparam int         PMR_NTGT      = 7;

  // maskable bits per target, 19 in all; word target bit 2 is status word bit 10
  localparam logic [6:0][7:0] PMR_MASK_USED = {8'hc0, 8'hf0, 8'hc0, 8'he0,
                                               8'hd0, 8'hf0, 8'h04};
  localparam logic [6:0][7:0] PMR_MASK_RST  = {8'h00, 8'h00, 8'h00, 8'h00,
                                               8'h00, 8'h00, 8'h04};

  // setpoint ranges per divider ratio code (0: one, 1: half, 2: quarter)
  localparam logic [11:0] PMR_R1_LO = 12'h100;
  localparam logic [11:0] PMR_R1_HI = 12'h300;
  localparam logic [11:0] PMR_R2_LO = 12'h200;
  localparam logic [11:0] PMR_R2_HI = 12'h600;
  localparam logic [11:0] PMR_R4_LO = 12'h400;
  localparam logic [11:0] PMR_R4_HI = 12'hc00;

  typedef logic [6:0][7:0] pmr_mask_arr_t;

  typedef enum logic [0:0] {
    PMR_ST_LOAD = 1'b0,
    PMR_ST_RUN  = 1'b1
  } pmr_state_t;

  // one decoded bus transaction from the protocol front end
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [7:0]  count;
    logic [15:0] data;
  } pmr_req_t;

  typedef struct packed {
    logic        valid;
    logic        nack;
    logic [7:0]  count;
    logic [15:0] data;
  } pmr_rsp_t;

  // limits held elsewhere in the device
  typedef struct packed {
    logic [11:0] floor_lvl;
    logic [11:0] ceiling_lvl;
    logic [11:0] overvoltage_warn_level;
    logic [11:0] undervoltage_warn_level;
    logic [1:0]  ratio;
  } pmr_lim_t;

  typedef struct packed {
    logic          valid;
    logic [11:0]   setpoint;
    pmr_mask_arr_t masks;
  } pmr_nvm_t;

endpackage

// ==== core/pmr_regs.sv ====
// setpoint, format, feature and alert mask command registers
`timescale 1ns/1ps

// Function
// - read-only feature byte reads 1011 0000: checking, 400 kHz, alert protocol.
// - mask write is a word write: target code byte, then mask byte stored.
// - mask read uses block write-read, count one; other counts are NACKed.
// - every mask read with count one after the load cycle answers block count one, then the target's mask byte, or zero for an unaccepted target.
// - a set mask bit stops that status bit from raising the alert.
// - nineteen maskable sources, each mask bit kept in nonvolatile storage.
// - only word, vout, iout, input, temp, comm and vendor targets accepted.
// - mask write to other target sets comm fault, invalid data, alert.
// - mask read of an unaccepted target returns zero.
// - code 79h reaches power-good-low mask, word bit 10; resets to one.
// - format byte read-only: linear mode 000, exponent 10111.
// - setpoint is unsigned mantissa, top four bits zero, resets to 486.
// - valid setpoint range follows divider ratio one, half or quarter.
// - setpoint below floor or above ceiling is clamped to that limit.
// - setpoint kept unless new value is strictly inside the warn levels.
// - setpoint rejected by warn levels sets comm fault, invalid data, alert.
// - at power-up the strap mantissa overrides the restored setpoint.
// - save-all hands the setpoint to nonvolatile storage.
module pmr_regs (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire pmr_pkg::pmr_req_t     req,
  input  wire pmr_pkg::pmr_lim_t     lim,
  input  wire logic                  strap_en,
  input  wire logic [11:0]           strap_mantissa,
  input  wire logic [11:0]           nvm_setpoint,
  input  wire pmr_pkg::pmr_mask_arr_t nvm_masks,
  input  wire logic                  save_all,
  input  wire pmr_pkg::pmr_mask_arr_t status_events,
  output pmr_pkg::pmr_rsp_t          rsp,
  output logic                       cml_set,
  output logic                       ivd_set,
  output logic                       clamp_evt,
  output logic                       alert_out,
  output logic [11:0]                setpoint,
  output pmr_pkg::pmr_nvm_t          nvm_store
);
  import pmr_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] tgt_idx(input logic [7:0] code);
    case (code)
      PMR_TGT_WORD:  tgt_idx = 3'h0;
      PMR_TGT_VOUT:  tgt_idx = 3'h1;
      PMR_TGT_IOUT:  tgt_idx = 3'h2;
      PMR_TGT_INPUT: tgt_idx = 3'h3;
      PMR_TGT_TEMP:  tgt_idx = 3'h4;
      PMR_TGT_CML:   tgt_idx = 3'h5;
      PMR_TGT_MFR:   tgt_idx = 3'h6;
      default:       tgt_idx = PMR_TGT_NONE;
    endcase
  endfunction

  function automatic logic [11:0] clamp(input logic [11:0] v,
                                        input logic [11:0] lo,
                                        input logic [11:0] hi);
    if (v < lo) begin
      clamp = lo;
    end else if (v > hi) begin
      clamp = hi;
    end else begin
      clamp = v;
    end
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  pmr_state_t    st_q;
  logic [11:0]   sp_q;
  pmr_mask_arr_t mask_q;
  pmr_rsp_t      rsp_q;
  logic          cml_q;
  logic          ivd_q;
  logic          clamp_q;
  logic          alert_q;
  pmr_nvm_t      nvm_q;

  // ---------------------------------------------------------------
  // request decode
  // ---------------------------------------------------------------
  logic          run;
  logic          mask_wr;
  logic          mask_rd;
  logic          sp_wr;
  logic [2:0]    wr_idx;
  logic [2:0]    rd_idx;
  logic          wr_bad_tgt;
  logic [11:0]   r_lo;
  logic [11:0]   r_hi;
  logic [11:0]   sp_ratio;
  logic [11:0]   sp_new;
  logic          sp_ok;
  logic          fault_evt;
  logic          src_active;

  assign run     = (st_q == PMR_ST_RUN);
  assign mask_wr = run && req.valid && req.write && req.code == PMR_CMD_MASK
                   && req.count == 8'h02;
  assign mask_rd = run && req.valid && !req.write && req.code == PMR_CMD_MASK;
  assign sp_wr   = run && req.valid && req.write && req.code == PMR_CMD_SETPOINT;
  assign wr_idx  = tgt_idx(req.data[7:0]);
  assign rd_idx  = tgt_idx(req.data[7:0]);
  assign wr_bad_tgt = mask_wr && (wr_idx == PMR_TGT_NONE);

  // ratio window; an unused ratio code falls back to ratio one
  // ratio range
  always_comb begin
    case (lim.ratio)
      2'h1: begin
        r_lo = PMR_R2_LO;
        r_hi = PMR_R2_HI;
      end
      2'h2: begin
        r_lo = PMR_R4_LO;
        r_hi = PMR_R4_HI;
      end
      default: begin
        r_lo = PMR_R1_LO;
        r_hi = PMR_R1_HI;
      end
    endcase
  end

  // checks see the limits of this cycle, the old setpoint still in place
  // same-cycle limits
  assign sp_ratio = clamp(req.data[11:0], r_lo, r_hi);
  assign sp_new   = clamp(sp_ratio, lim.floor_lvl, lim.ceiling_lvl);
  assign sp_ok    = (sp_new < lim.overvoltage_warn_level)
                    && (sp_new > lim.undervoltage_warn_level);

  assign fault_evt = wr_bad_tgt || (sp_wr && !sp_ok);

  assign src_active = |(status_events & ~mask_q & PMR_MASK_USED);

  // ---------------------------------------------------------------
  // power-up load then run
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= PMR_ST_LOAD;
    end else begin
      case (st_q)
        PMR_ST_LOAD: st_q <= PMR_ST_RUN;
        PMR_ST_RUN:  st_q <= PMR_ST_RUN;
        default:     st_q <= PMR_ST_LOAD;
      endcase
    end
  end

  // setpoint: restored copy, strap override, then host writes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sp_q <= PMR_SP_RST;
    end else if (st_q == PMR_ST_LOAD) begin
      sp_q <= strap_en ? strap_mantissa : nvm_setpoint;
    end else if (sp_wr && sp_ok) begin
      sp_q <= sp_new;
    end
  end

  // mask bytes; unused bit positions never hold a one
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask_q <= PMR_MASK_RST;
    end else if (st_q == PMR_ST_LOAD) begin
      mask_q <= nvm_masks & PMR_MASK_USED;
    end else if (mask_wr && !wr_bad_tgt) begin
      mask_q[wr_idx] <= req.data[15:8] & PMR_MASK_USED[wr_idx];
    end
  end

  // answers, one cycle after each request
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rsp_q <= '0;
    end else begin
      rsp_q       <= '0;
      rsp_q.valid <= req.valid;
      if (!run) begin
        rsp_q.nack <= req.valid;
      end else if (req.valid) begin
        case (req.code)
          PMR_CMD_FEATURE: begin
            rsp_q.nack <= req.write;
            rsp_q.data <= {8'h00, PMR_FEATURE_VAL};
          end
          PMR_CMD_VFORMAT: begin
            rsp_q.nack <= req.write;
            rsp_q.data <= {8'h00, PMR_VMODE_LIN, PMR_VEXP_M9};
          end
          PMR_CMD_SETPOINT: begin
            rsp_q.data <= {4'h0, sp_q};
          end
          PMR_CMD_MASK: begin
            if (req.write) begin
              rsp_q.nack <= (req.count != 8'h02);
            end else if (req.count != PMR_MASK_CNT) begin
              rsp_q.nack <= 1'b1;
            end else begin
              rsp_q.count <= PMR_MASK_CNT;
              rsp_q.data  <= (rd_idx == PMR_TGT_NONE) ? 16'h0000
                             : {8'h00, mask_q[rd_idx]};
            end
          end
          default: rsp_q.nack <= 1'b1;
        endcase
      end
    end
  end

  // fault pulses toward the status block
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cml_q   <= 1'b0;
      ivd_q   <= 1'b0;
      clamp_q <= 1'b0;
    end else begin
      cml_q   <= fault_evt;
      ivd_q   <= fault_evt;
      clamp_q <= sp_wr && sp_ok && (sp_new != req.data[11:0]);
    end
  end

  // alert level; own faults assert it for at least a cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= src_active || fault_evt;
    end
  end

  // snapshot for the save-all engine
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      nvm_q <= '0;
    end else begin
      nvm_q.valid    <= save_all;
      nvm_q.setpoint <= sp_q;
      nvm_q.masks    <= mask_q;
    end
  end

  assign rsp       = rsp_q;
  assign cml_set   = cml_q;
  assign ivd_set   = ivd_q;
  assign clamp_evt = clamp_q;
  assign alert_out = alert_q;
  assign setpoint  = sp_q;
  assign nvm_store = nvm_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_mask_rd_ok;
    mask_rd && req.count == PMR_MASK_CNT;
  endsequence
  sequence s_sp_reject;
    sp_wr && !sp_ok;
  endsequence

  property p_feature;
    run && req.valid && !req.write && req.code == PMR_CMD_FEATURE
      |=> rsp.valid && !rsp.nack && rsp.data == 16'h00b0;
  endproperty
  a_feature: assert property (p_feature) else $error("feature byte wrong");

  property p_mask_store;
    mask_wr && wr_idx == 3'h4
      |=> mask_q[4] == ($past(req.data[15:8]) & PMR_MASK_USED[4]);
  endproperty
  a_mask_store: assert property (p_mask_store) else $error("mask not stored");

  property p_count_nack;
    mask_rd && req.count != PMR_MASK_CNT |=> rsp.valid && rsp.nack;
  endproperty
  a_count_nack: assert property (p_count_nack) else $error("bad count not nacked");

  property p_count_one;
    s_mask_rd_ok |=> !rsp.nack && rsp.count == 8'h01;
  endproperty
  a_count_one: assert property (p_count_one) else $error("mask read count not one");

  property p_masked_quiet;
    !src_active && !fault_evt |=> !alert_out;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("masked alert leaked");

  property p_bad_tgt;
    wr_bad_tgt |=> cml_set && ivd_set && alert_out && mask_q == $past(mask_q);
  endproperty
  a_bad_tgt: assert property (p_bad_tgt) else $error("bad target not flagged");

  property p_bad_rd_zero;
    s_mask_rd_ok ##0 rd_idx == PMR_TGT_NONE |=> rsp.data == 16'h0000;
  endproperty
  a_bad_rd_zero: assert property (p_bad_rd_zero) else $error("bad target read nonzero");

  property p_format;
    run && req.valid && !req.write && req.code == PMR_CMD_VFORMAT |=> rsp.data == 16'h0017;
  endproperty
  a_format: assert property (p_format) else $error("format byte wrong");

  property p_reject;
    s_sp_reject |=> setpoint == $past(setpoint) && cml_set && ivd_set && alert_out
      ##1 (!cml_set || $past(fault_evt));
  endproperty
  a_reject: assert property (p_reject) else $error("rejected setpoint changed");

  property p_window;
    sp_wr && sp_ok |=> setpoint > $past(lim.undervoltage_warn_level)
                       && setpoint < $past(lim.overvoltage_warn_level);
  endproperty
  a_window: assert property (p_window) else $error("setpoint outside warn window");

  property p_strap;
    st_q == PMR_ST_LOAD && strap_en |=> setpoint == $past(strap_mantissa);
  endproperty
  a_strap: assert property (p_strap) else $error("strap value not loaded");

  property p_save;
    save_all |=> nvm_store.valid && nvm_store.setpoint == $past(setpoint);
  endproperty
  a_save: assert property (p_save) else $error("save-all snapshot wrong");

endmodule

// ==== verification/pmr_host_model.sv ====
// host controller model issuing decoded bus transactions
`timescale 1ns/1ps
module pmr_host_model (
  input  wire logic    sys_clk,
  output pmr_pkg::pmr_req_t req
);
  import pmr_pkg::*;

  // ----------------------------------------
  // request driver
  // ----------------------------------------
  initial req = '0;

  // one request per call, then idle; a released bus shows the inverse, not old data
  task automatic send(input logic wr, input logic [7:0] code, input logic [7:0] cnt,
                      input logic [15:0] dat, input int gap);
    @(negedge sys_clk);
    req <= '{1'b1, wr, code, cnt, dat};
    @(negedge sys_clk);
    req <= '{1'b0, ~wr, ~code, ~cnt, ~dat};
    repeat (gap) @(negedge sys_clk);
  endtask
endmodule

// ==== verification/tb.sv ====
// self-checking bench for the setpoint and alert mask registers
`timescale 1ns/1ps
module tb;
  import pmr_pkg::*;

  typedef struct {
    logic        nk;
    logic        rd;
    logic        mr;
    logic [15:0] dat;
    logic        fl;
    logic        cl;
  } pmr_exp_t;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic          sys_clk;
  logic          rst;
  pmr_req_t      req;
  pmr_lim_t      lim;
  logic          strap_en;
  logic [11:0]   strap_mantissa;
  logic [11:0]   nvm_setpoint;
  pmr_mask_arr_t nvm_masks;
  logic          save_all;
  pmr_mask_arr_t status_events;
  pmr_rsp_t      rsp;
  logic          cml_set;
  logic          ivd_set;
  logic          clamp_evt;
  logic          alert_out;
  logic [11:0]   setpoint;
  pmr_nvm_t      nvm_store;
  pmr_exp_t      notes[$];
  pmr_mask_arr_t mk;
  logic [7:0]    rv;
  logic [7:0]    tgt[7] = '{8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h80};
  logic [11:0]   lo[3]  = '{12'd256, 12'd512, 12'd1024};
  logic [11:0]   hi[3]  = '{12'd768, 12'd1536, 12'd3072};
  integer        seed = 32'h22daa491;
  int            err_total = 0;
  int            comparisons = 0;

  pmr_host_model u_host (.sys_clk(sys_clk), .req(req));

  pmr_regs uut (
    .sys_clk(sys_clk), .rst(rst), .req(req), .lim(lim), .strap_en(strap_en),
    .strap_mantissa(strap_mantissa), .nvm_setpoint(nvm_setpoint), .nvm_masks(nvm_masks),
    .save_all(save_all), .status_events(status_events), .rsp(rsp), .cml_set(cml_set),
    .ivd_set(ivd_set), .clamp_evt(clamp_evt), .alert_out(alert_out), .setpoint(setpoint),
    .nvm_store(nvm_store)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (err_total == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // note the expectation first, the answer comes one cycle after the request
  task automatic op(input logic wr, input logic [7:0] code, input logic [7:0] cnt,
                    input logic [15:0] dat, input logic nk, input logic [15:0] ed,
                    input logic fl, input logic cl);
    notes.push_back('{nk, !wr, !wr && code == PMR_CMD_MASK, ed, fl, cl});
    u_host.send(wr, code, cnt, dat, 2 + int'($unsigned($random(seed)) % 3));
  endtask

  task automatic rd(input logic [7:0] code, input logic [15:0] ed);
    op(1'b0, code, 8'h01, 16'h0000, 1'b0, ed, 1'b0, 1'b0);
  endtask

  // mask read: block count one, target byte in the data field
  task automatic mrd(input logic [7:0] t, input logic [7:0] m);
    op(1'b0, PMR_CMD_MASK, 8'h01, {8'h00, t}, 1'b0, {8'h00, m}, 1'b0, 1'b0);
  endtask

  // mask write: target code low byte, mask high byte
  task automatic mwr(input logic [7:0] t, input logic [7:0] m, input logic fl);
    op(1'b1, PMR_CMD_MASK, 8'h02, {m, t}, 1'b0, 16'h0000, fl, 1'b0);
  endtask

  task automatic spw(input logic [15:0] v, input logic [11:0] ex, input logic fl,
                     input logic cl);
    op(1'b1, PMR_CMD_SETPOINT, 8'h02, v, 1'b0, 16'h0000, fl, cl);
    rd(PMR_CMD_SETPOINT, {4'h0, ex});
  endtask

  // ----------------------------------------
  // clock, watchdog, answer monitor
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  initial begin
    #(25 * 20000);
    err_total++;
    print_verdict();
  end

  // answers are sampled mid-cycle; alert may follow the fault pulse by one cycle
  initial begin
    pmr_exp_t e;
    logic     a;
    forever begin
      @(negedge sys_clk);
      if (rsp.valid === 1'b1) begin
        if (notes.size() == 0) begin
          chk("unasked answer", 1'b1, 1'b0);
        end else begin
          e = notes.pop_front();
          chk("nack", rsp.nack, e.nk);
          if (!e.nk && e.rd) chk("read data", rsp.data, e.dat);
          if (!e.nk && e.mr) chk("block count", rsp.count, 8'h01);
          chk("fault pulses", {cml_set, ivd_set}, {2{e.fl}});
          if (!e.nk) chk("clamp", clamp_evt, e.cl);
          a = alert_out;
          @(negedge sys_clk);
          if (e.fl) chk("fault alert", a | alert_out, 1'b1);
        end
      end
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    lim = {12'h000, 12'hfff, 12'hfff, 12'h000, 2'd0};
    strap_en = 1'b1;
    strap_mantissa = 12'h155;
    nvm_setpoint = 12'h2aa;
    nvm_masks = 56'({$random(seed), $random(seed)});
    nvm_masks[0][2] = 1'b1;
    save_all = 1'b0;
    status_events = '0;
    mk = nvm_masks & PMR_MASK_USED;
    repeat (10) @(negedge sys_clk);
    chk("reset setpoint", setpoint, 12'd486);
    rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("strap setpoint", setpoint, 12'h155);
    rd(PMR_CMD_FEATURE, 16'h00b0);
    rd(PMR_CMD_VFORMAT, 16'h0017);
    op(1'b1, PMR_CMD_FEATURE, 8'h01, 16'h0012, 1'b1, 16'h0, 1'b0, 1'b0);
    op(1'b1, PMR_CMD_VFORMAT, 8'h01, 16'h0012, 1'b1, 16'h0, 1'b0, 1'b0);
    for (int i = 0; i < 7; i++) mrd(tgt[i], mk[i]);
    for (int i = 0; i < 7; i++) begin
      rv = 8'($random(seed));
      mk[i] = rv & PMR_MASK_USED[i];
      mwr(tgt[i], rv, 1'b0);
      mrd(tgt[i], mk[i]);
    end
    mwr(8'h79, 8'h04, 1'b0);
    mrd(8'h79, 8'h04);
    mk[0] = 8'h04;
    mwr(8'h81, 8'hff, 1'b1);
    mrd(8'h81, 8'h00);
    op(1'b0, PMR_CMD_MASK, 8'h02, 16'h007d, 1'b1, 16'h0, 1'b0, 1'b0);
    op(1'b0, PMR_CMD_MASK, 8'h00, 16'h007d, 1'b1, 16'h0, 1'b0, 1'b0);
    // unknown command code is refused
    op(1'b0, 8'h42, 8'h01, 16'h0000, 1'b1, 16'h0, 1'b0, 1'b0);
    // masked temperature warning and power-good-low must stay quiet
    mwr(8'h7d, 8'h40, 1'b0);
    status_events[4] = 8'h40;
    status_events[0] = 8'h04;
    repeat (3) @(negedge sys_clk);
    chk("masked alert", alert_out, 1'b0);
    mwr(8'h7d, 8'h00, 1'b0);
    mk[4] = 8'h00;
    repeat (3) @(negedge sys_clk);
    chk("unmasked alert", alert_out, 1'b1);
    status_events = '0;
    for (int r = 0; r < 3; r++) begin
      lim = {12'h000, 12'hfff, 12'hfff, 12'h000, 2'(r)};
      spw(16'h0000, lo[r], 1'b0, 1'b1);
      spw(16'hffff, hi[r], 1'b0, 1'b1);
    end
    // spare ratio code behaves as ratio one
    lim.ratio = 2'd3;
    spw(16'h0000, 12'd256, 1'b0, 1'b1);
    lim = {12'h120, 12'h2c0, 12'h2d0, 12'h110, 2'd0};
    spw(16'h01ff, 12'h1ff, 1'b0, 1'b0);
    spw(16'h02f0, 12'h2c0, 1'b0, 1'b1);
    spw(16'h0050, 12'h120, 1'b0, 1'b1);
    lim.overvoltage_warn_level = 12'h200;
    lim.undervoltage_warn_level = 12'h150;
    spw(16'h0200, 12'h120, 1'b1, 1'b0);
    spw(16'h0150, 12'h120, 1'b1, 1'b0);
    spw(16'h01ff, 12'h1ff, 1'b0, 1'b0);
    @(negedge sys_clk);
    save_all = 1'b1;
    @(negedge sys_clk);
    save_all = 1'b0;
    chk("save valid", nvm_store.valid, 1'b1);
    chk("save setpoint", nvm_store.setpoint, 12'h1ff);
    chk("save masks", nvm_store.masks, mk);
    repeat (5) @(negedge sys_clk);
    chk("notes left", notes.size(), 0);
    print_verdict();
  end
endmodule
